// ===== fdpc_ctrl.sv
// Purpose: Command controller for a 160-page, four-byte-page data array
// Assumes: Core samples o_core_stall and waits while it is high
// Notes: Read data is registered, valid the cycle after the address
module fdpc_ctrl
   import fdpc_pkg::*;
#(
   parameter int NUM_PAGES = PAGES
)
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // Register bus from the core
   input fdpc_pkg::fdpc_sfr_req_t i_sfr,
   output logic [7:0] o_sfr_rdata,
   // Core stall
   output logic o_core_stall
);
   import fdpc_pkg::*;

   if (NUM_PAGES != PAGES)
   begin : g_bad_pages
      $error("Page count must match the page select decode");
   end

   logic [31:0] page_q [NUM_PAGES];
   logic [7:0] cmd_q;
   logic [7:0] sel_q;
   logic [7:0] data_q [PAGE_BYTES];
   logic [15:0] tword_q;
   logic [7:0] taux_q;
   fdpc_state_t state_q;
   logic [15:0] pre_q;
   logic [9:0] half_q;
   logic [7:0] rdata_q;
   logic stall_q;

   // Decode
   wire idle = (state_q == ST_IDLE);
   wire wr_ok = i_sfr.wr && idle;
   wire wr_cmd = wr_ok && (i_sfr.addr == ADDR_FLASH_COMMAND);
   wire wr_sel = wr_ok && (i_sfr.addr == ADDR_PAGE_SELECT);
   wire wr_tlo = wr_ok && (i_sfr.addr == ADDR_TIMING_WORD_LOW);
   wire wr_thi = wr_ok && (i_sfr.addr == ADDR_TIMING_WORD_HIGH);
   wire wr_taux = wr_ok && (i_sfr.addr == ADDR_TIMING_AUX);
   wire sel_valid = (sel_q <= LAST_PAGE);
   wire [31:0] page_word = sel_valid ? page_q[sel_q] : ERASED_PAGE;
   wire [31:0] data_word = {data_q[3], data_q[2], data_q[1], data_q[0]};
   wire cmd_read = wr_cmd && (i_sfr.wdata == CMD_READ);
   wire cmd_prog = wr_cmd && (i_sfr.wdata == CMD_PROGRAM);
   wire cmd_verify = wr_cmd && (i_sfr.wdata == CMD_VERIFY);
   wire cmd_erase = wr_cmd && (i_sfr.wdata == CMD_ERASE);
   wire cmd_erase_all = wr_cmd && (i_sfr.wdata == CMD_ERASE_ALL);
   wire op_start = cmd_prog || cmd_erase || cmd_erase_all;

   // Timing: a zero word still ticks every cycle rather than hanging
   wire [15:0] half_word = {1'b0, tword_q[15:1]};
   wire tick = (pre_q + 16'h0001 >= half_word);
   wire [9:0] target = (state_q == ST_PROG) ? PROG_HALVES : ERASE_HALVES;
   wire done = !idle && tick && (half_q + 10'h001 >= target);
   wire prog_done = done && (state_q == ST_PROG);
   wire erase_done = done && (state_q == ST_ERASE);
   wire erase_all_done = done && (state_q == ST_ERASE_ALL);

   // Read mux
   logic [7:0] rd_mux;
   always_comb
   begin
      case (i_sfr.addr)
         ADDR_FLASH_COMMAND: rd_mux = cmd_q;
         ADDR_PAGE_DATA_BYTE1: rd_mux = data_q[0];
         ADDR_PAGE_DATA_BYTE2: rd_mux = data_q[1];
         ADDR_PAGE_DATA_BYTE3: rd_mux = data_q[2];
         ADDR_PAGE_DATA_BYTE4: rd_mux = data_q[3];
         ADDR_PAGE_SELECT: rd_mux = sel_q;
         ADDR_TIMING_WORD_LOW: rd_mux = tword_q[7:0];
         ADDR_TIMING_WORD_HIGH: rd_mux = tword_q[15:8];
         ADDR_TIMING_AUX: rd_mux = taux_q;
         default: rd_mux = 8'h00;
      endcase
   end

   // Array: programming only clears bits, so a byte must read ff first
   for (genvar p = 0; p < NUM_PAGES; p++)
   begin : g_page
      wire hit = sel_valid && (sel_q == 8'(p));
      always_ff @(posedge i_ref_clk or posedge i_reset)
      begin
         if (i_reset)
            page_q[p] <= ERASED_PAGE;
         else if (erase_all_done || (erase_done && hit))
            page_q[p] <= ERASED_PAGE;
         else if (prog_done && hit)
            page_q[p] <= page_q[p] & data_word;
      end
   end

   // Data registers
   for (genvar b = 0; b < PAGE_BYTES; b++)
   begin : g_data
      wire wr_b = wr_ok && (i_sfr.addr == ADDR_PAGE_DATA_BYTE1 + 8'(b));
      always_ff @(posedge i_ref_clk or posedge i_reset)
      begin
         if (i_reset)
            data_q[b] <= RST_PAGE_DATA;
         else if (cmd_read)
            data_q[b] <= page_word[8*b +: 8];
         else if (wr_b)
            data_q[b] <= i_sfr.wdata;
      end
   end

   // Command register; verify overwrites it with the outcome
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
         cmd_q <= RST_FLASH_COMMAND;
      else if (cmd_verify)
         cmd_q <= (page_word == data_word) ? VERIFY_PASS : VERIFY_FAIL;
      else if (wr_cmd)
         cmd_q <= i_sfr.wdata;
   end

   // Configuration registers
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         sel_q <= RST_PAGE_SELECT;
         tword_q <= RST_TIMING_WORD;
         taux_q <= RST_TIMING_AUX;
      end
      else
      begin
         if (wr_sel)
            sel_q <= i_sfr.wdata;
         if (wr_tlo)
            tword_q[7:0] <= i_sfr.wdata;
         if (wr_thi)
            tword_q[15:8] <= i_sfr.wdata;
         if (wr_taux)
            taux_q <= i_sfr.wdata;
      end
   end

   // Sequencer; reserved codes are stored but start nothing
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
         state_q <= ST_IDLE;
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (cmd_prog)
                  state_q <= ST_PROG;
               else if (cmd_erase)
                  state_q <= ST_ERASE;
               else if (cmd_erase_all)
                  state_q <= ST_ERASE_ALL;
            end
            ST_PROG, ST_ERASE, ST_ERASE_ALL:
            begin
               if (done)
                  state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Prescaler and half-unit counter
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         pre_q <= 16'h0000;
         half_q <= 10'h000;
      end
      else if (idle || done)
      begin
         pre_q <= 16'h0000;
         half_q <= 10'h000;
      end
      else if (tick)
      begin
         pre_q <= 16'h0000;
         half_q <= half_q + 10'h001;
      end
      else
         pre_q <= pre_q + 16'h0001;
   end

   // Outputs; stall covers only the timed operations, other logic runs on
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         stall_q <= 1'b0;
         rdata_q <= 8'h00;
      end
      else
      begin
         stall_q <= op_start || (!idle && !done);
         rdata_q <= rd_mux;
      end
   end

   assign o_core_stall = stall_q;
   assign o_sfr_rdata = rdata_q;

   // Checks
   a_prog_stalls: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      cmd_prog |=> o_core_stall)
      else $error("Program did not stall the core");
   a_read_no_stall: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      cmd_read |=> !o_core_stall)
      else $error("Read stalled the core");
   a_read_loads: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      cmd_read |=> (data_word == $past(page_word)))
      else $error("Read did not load the page");
   a_verify_result: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      cmd_verify |=> ((cmd_q == VERIFY_PASS) == $past(page_word == data_word)))
      else $error("Verify result wrong");
   a_erase_page_ff: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      erase_done |=> (page_word == ERASED_PAGE))
      else $error("Page not erased");
   a_erase_all_ff: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      erase_all_done |=> (page_q[0] == ERASED_PAGE && page_q[NUM_PAGES-1] == ERASED_PAGE))
      else $error("Array not erased");
   a_prog_clears: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (prog_done && sel_valid) |=> ((page_word & ~data_word) == 32'h0000_0000))
      else $error("Program set a bit");
   a_busy_ignores: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (!idle && i_sfr.wr) |=> ($stable(sel_q) && $stable(data_word)))
      else $error("Write taken while busy");
   a_half_bound: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      !idle |-> (half_q < target))
      else $error("Half-unit count overran");
   a_stall_ends: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      done |=> !o_core_stall)
      else $error("Stall held past completion");

   // Cycles spent in a timed state, counted apart from the prescaler
   logic [25:0] busy_cyc_q;
   wire [25:0] exp_cyc = target * ((half_word == 16'h0000) ? 16'h0001 : half_word);
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
         busy_cyc_q <= 26'h0000000;
      else if (idle)
         busy_cyc_q <= 26'h0000000;
      else
         busy_cyc_q <= busy_cyc_q + 26'h0000001;
   end

   a_erase_stalls: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (cmd_erase || cmd_erase_all) |=> o_core_stall)
      else $error("Erase did not stall the core");
   a_idle_no_stall: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (idle && !op_start) |=> !o_core_stall)
      else $error("Stall raised while idle");
   a_busy_stalls: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (!idle && !done) |=> o_core_stall)
      else $error("Stall dropped during operation");
   a_verify_no_stall: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      cmd_verify |=> !o_core_stall)
      else $error("Verify stalled the core");
   a_op_length: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      done |-> ((busy_cyc_q + 26'h0000001) == exp_cyc))
      else $error("Operation length wrong");
   a_tick_advance: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (!idle && tick && !done) |=> (half_q == $past(half_q) + 10'h001))
      else $error("Half-unit count did not advance");
   a_erase_others: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (erase_done && sel_q != 8'h00) |=> (page_q[0] == $past(page_q[0])))
      else $error("Page erase touched another page");
   a_prog_others: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (prog_done && sel_q != 8'h00) |=> (page_q[0] == $past(page_q[0])))
      else $error("Program touched another page");
   a_data_kept: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (prog_done || erase_done || erase_all_done) |=> $stable(data_word))
      else $error("Data registers changed by operation");
   a_sel_write: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      wr_sel |=> (sel_q == $past(i_sfr.wdata)))
      else $error("Page select write lost");
   a_cmd_stored: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (wr_cmd && !cmd_verify) |=> (cmd_q == $past(i_sfr.wdata)))
      else $error("Command code not stored");
   a_data_write: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (wr_ok && i_sfr.addr == ADDR_PAGE_DATA_BYTE1) |=> (data_q[0] == $past(i_sfr.wdata)))
      else $error("Data byte write lost");
   a_read_bad_page: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (cmd_read && !sel_valid) |=> (data_word == ERASED_PAGE))
      else $error("Read beyond last page not erased value");
   a_tlo_write: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      wr_tlo |=> (tword_q[7:0] == $past(i_sfr.wdata)))
      else $error("Timing low byte write lost");
   a_thi_write: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      wr_thi |=> (tword_q[15:8] == $past(i_sfr.wdata)))
      else $error("Timing high byte write lost");
   a_verify_fail_code: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (cmd_verify && (page_word != data_word)) |=> (cmd_q != VERIFY_PASS))
      else $error("Verify mismatch read as zero");
   a_done_idles: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      done |=> idle)
      else $error("Sequencer stayed busy after completion");
   a_cmd_held_busy: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (!idle && i_sfr.wr) |=> $stable(cmd_q))
      else $error("Command written while busy");
   a_tword_held_busy: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (!idle && i_sfr.wr) |=> $stable(tword_q))
      else $error("Timing word written while busy");

   c_program: cover property (@(posedge i_ref_clk) disable iff (i_reset) prog_done);
   c_erase_all: cover property (@(posedge i_ref_clk) disable iff (i_reset) erase_all_done);
   c_verify_fail: cover property (@(posedge i_ref_clk) disable iff (i_reset)
      cmd_verify && (page_word != data_word));
   c_erase_page: cover property (@(posedge i_ref_clk) disable iff (i_reset) erase_done);
   c_busy_write: cover property (@(posedge i_ref_clk) disable iff (i_reset)
      !idle && i_sfr.wr);
endmodule

// ===== fdpc_pkg.sv
// Purpose: Shared constants and types for the data page command controller
// Assumes: Byte-wide special function register bus from the core
// Notes: Unprinted register addresses are fixed here once
package fdpc_pkg;
   // Array geometry
   localparam int PAGES = 160;
   localparam int PAGE_BYTES = 4;
   localparam logic [7:0] LAST_PAGE = 8'h9f;

   // Register addresses
   localparam logic [7:0] ADDR_FLASH_COMMAND = 8'hb9;
   localparam logic [7:0] ADDR_PAGE_DATA_BYTE1 = 8'hbc;
   localparam logic [7:0] ADDR_PAGE_DATA_BYTE2 = 8'hbd;
   localparam logic [7:0] ADDR_PAGE_DATA_BYTE3 = 8'hbe;
   localparam logic [7:0] ADDR_PAGE_DATA_BYTE4 = 8'hbf;
   localparam logic [7:0] ADDR_PAGE_SELECT = 8'hc6;
   localparam logic [7:0] ADDR_TIMING_WORD_LOW = 8'hd1;
   localparam logic [7:0] ADDR_TIMING_WORD_HIGH = 8'hd2;
   localparam logic [7:0] ADDR_TIMING_AUX = 8'hd3;

   // Reset values
   localparam logic [7:0] RST_FLASH_COMMAND = 8'h00;
   localparam logic [7:0] RST_PAGE_DATA = 8'h00;
   localparam logic [7:0] RST_PAGE_SELECT = 8'h00;
   localparam logic [15:0] RST_TIMING_WORD = 16'h0452;
   localparam logic [7:0] RST_TIMING_AUX = 8'hc9;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [31:0] ERASED_PAGE = 32'hffff_ffff;

   // Command codes
   localparam logic [7:0] CMD_READ = 8'h01;
   localparam logic [7:0] CMD_PROGRAM = 8'h02;
   localparam logic [7:0] CMD_VERIFY = 8'h04;
   localparam logic [7:0] CMD_ERASE = 8'h05;
   localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
   localparam logic [7:0] VERIFY_PASS = 8'h00;
   localparam logic [7:0] VERIFY_FAIL = 8'h01;

   // Timing: the timing word spans 100 us, halved to reach 250 us exactly
   localparam int UNIT_TIME_US = 100;
   localparam int HALF_UNIT_US = UNIT_TIME_US / 2;
   localparam int PROG_TIME_US = 250;
   localparam int ERASE_TIME_MS = 20;
   localparam logic [9:0] PROG_HALVES = 10'(PROG_TIME_US / HALF_UNIT_US);
   localparam logic [9:0] ERASE_HALVES = 10'(ERASE_TIME_MS * 1000 / HALF_UNIT_US);

   typedef enum {ST_IDLE, ST_PROG, ST_ERASE, ST_ERASE_ALL} fdpc_state_t;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fdpc_sfr_req_t;
endpackage

// ===== fdpc_core_model.sv
// Purpose: Core-side model issuing register writes and reads to the controller
// Assumes: Bus signals change 1 ns after the rising edge
// Notes: Never issues codes 03h or 07h-ffh, so those paths stay unexercised
module fdpc_core_model
   import fdpc_pkg::*;
(
   // Clock
   input wire logic i_ref_clk,
   // Controller side
   input wire logic i_core_stall,
   input wire logic [7:0] i_sfr_rdata,
   output fdpc_pkg::fdpc_sfr_req_t o_sfr
);
   timeunit 1ns;
   timeprecision 1ps;

   initial o_sfr = '0;

   // Bounded so a stuck stall shows up as a bad cycle count
   task automatic wait_idle(output int cyc);
      cyc = 0;
      while (i_core_stall === 1'b1 && cyc < 2000)
      begin
         @(posedge i_ref_clk);
         #1;
         cyc++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit busy_ok = 0);
      int c;
      if (!busy_ok)
         wait_idle(c);
      @(posedge i_ref_clk);
      #1;
      o_sfr = '{wr: 1'b1, addr: a, wdata: d};
      @(posedge i_ref_clk);
      #1;
      o_sfr.wr = 1'b0;
      // Released data is inverted so stale values cannot pass
      o_sfr.wdata = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int c;
      wait_idle(c);
      @(posedge i_ref_clk);
      #1;
      o_sfr.addr = a;
      @(posedge i_ref_clk);
      #1;
      d = i_sfr_rdata;
   endtask

   // Command goes last, after page and data setup
   task automatic cmd(input logic [7:0] code, output int cyc);
      wr(ADDR_FLASH_COMMAND, code);
      wait_idle(cyc);
   endtask
endmodule

// ===== test_fdpc_ctrl.sv
// Purpose: Self-checking bench for the data page command controller
// Assumes: Timing word shortened to 4 clocks per 100 us unit
// Notes: Durations checked to one cycle either side
module test_fdpc_ctrl
   import fdpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TW = 4;
   localparam int PROG_CYC = 250 * TW / 100;
   localparam int ERASE_CYC = 20000 * TW / 100;
   logic i_ref_clk;
   logic i_reset;
   fdpc_sfr_req_t sfr;
   logic [7:0] rdata;
   logic stall;
   int n_fail = 0;
   int checks = 0;

   fdpc_ctrl dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_sfr(sfr),
      .o_sfr_rdata(rdata), .o_core_stall(stall));
   fdpc_core_model core (.i_ref_clk(i_ref_clk), .i_core_stall(stall),
      .i_sfr_rdata(rdata), .o_sfr(sfr));

   initial
   begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic check_cyc(input string what, input int cyc, input int e);
      check(what, (cyc >= e - 1 && cyc <= e + 1) ? e : cyc, e);
   endtask

   task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      core.rd(a, v);
      check($sformatf("reg %h", a), {24'h0, v}, {24'h0, e});
   endtask

   task automatic set_page(input logic [7:0] p, input logic [31:0] d);
      core.wr(ADDR_PAGE_SELECT, p);
      for (int i = 0; i < PAGE_BYTES; i++)
         core.wr(8'(ADDR_PAGE_DATA_BYTE1 + i), d[8*i +: 8]);
   endtask

   task automatic expect_data(input logic [31:0] e);
      for (int i = 0; i < PAGE_BYTES; i++)
         expect_reg(8'(ADDR_PAGE_DATA_BYTE1 + i), e[8*i +: 8]);
   endtask

   // Loads the page through the read command, then compares
   task automatic expect_array(input logic [7:0] p, input logic [31:0] e);
      int c;
      core.wr(ADDR_PAGE_SELECT, p);
      core.cmd(CMD_READ, c);
      check_cyc("read stall", c, 0);
      expect_data(e);
   endtask

   task automatic t_reset_values;
      expect_reg(ADDR_FLASH_COMMAND, 8'h00);
      expect_data(32'h0);
      expect_reg(ADDR_PAGE_SELECT, 8'h00);
      expect_reg(ADDR_TIMING_WORD_LOW, 8'h52);
      expect_reg(ADDR_TIMING_WORD_HIGH, 8'h04);
      expect_reg(ADDR_TIMING_AUX, 8'hc9);
      expect_reg(8'hc0, 8'h00);
      expect_array(8'h00, 32'hffff_ffff);
      $display("test reset values done");
   endtask

   logic [7:0] rdata_seen;
   task automatic t_program_verify;
      int c;
      core.wr(ADDR_TIMING_WORD_LOW, 8'(TW));
      core.wr(ADDR_TIMING_WORD_HIGH, 8'h00);
      set_page(LAST_PAGE, 32'h1234_5678);
      core.cmd(CMD_PROGRAM, c);
      check_cyc("program cycles", c, PROG_CYC);
      expect_data(32'h1234_5678);
      core.cmd(CMD_VERIFY, c);
      expect_reg(ADDR_FLASH_COMMAND, VERIFY_PASS);
      set_page(LAST_PAGE, 32'h1234_5679);
      core.cmd(CMD_VERIFY, c);
      core.rd(ADDR_FLASH_COMMAND, rdata_seen);
      check("verify mismatch", 32'(rdata_seen != 8'h00), 32'h1);
      expect_array(LAST_PAGE, 32'h1234_5678);
      set_page(LAST_PAGE, 32'h0f0f_0f0f);
      core.cmd(CMD_ERASE, c);
      core.cmd(CMD_PROGRAM, c);
      expect_array(LAST_PAGE, 32'h0f0f_0f0f);
      $display("test program and verify done");
   endtask

   task automatic t_erase;
      int c;
      set_page(8'h9e, 32'ha5a5_a5a5);
      core.cmd(CMD_PROGRAM, c);
      core.wr(ADDR_PAGE_SELECT, LAST_PAGE);
      core.cmd(CMD_ERASE, c);
      check_cyc("erase cycles", c, ERASE_CYC);
      expect_array(LAST_PAGE, 32'hffff_ffff);
      expect_array(8'h9e, 32'ha5a5_a5a5);
      core.cmd(CMD_ERASE_ALL, c);
      check_cyc("erase all cycles", c, ERASE_CYC);
      expect_array(8'h9e, 32'hffff_ffff);
      $display("test erase done");
   endtask

   task automatic t_busy_drop;
      set_page(8'h10, 32'h0000_0000);
      core.wr(ADDR_FLASH_COMMAND, CMD_PROGRAM);
      check("stall at start", {31'h0, stall}, 32'h1);
      core.wr(ADDR_PAGE_SELECT, 8'h20, 1);
      check("stall held", {31'h0, stall}, 32'h1);
      expect_reg(ADDR_PAGE_SELECT, 8'h10);
      expect_array(8'h10, 32'h0000_0000);
      $display("test busy write done");
   endtask

   // One byte changed in place, the other three kept
   task automatic t_modify_byte;
      int c;
      set_page(8'h03, 32'h4433_2211);
      core.cmd(CMD_PROGRAM, c);
      set_page(8'h03, 32'h0000_0000);
      core.cmd(CMD_READ, c);
      core.wr(ADDR_PAGE_DATA_BYTE2, 8'hf3);
      core.cmd(CMD_ERASE, c);
      core.cmd(CMD_PROGRAM, c);
      expect_array(8'h03, 32'h4433_f311);
      expect_array(8'ha0, 32'hffff_ffff);
      $display("test byte modify done");
   endtask

   // Reset lands in the middle of a full erase; run last, it restores the slow timing
   task automatic t_reset_mid;
      core.wr(ADDR_PAGE_SELECT, 8'h05);
      core.wr(ADDR_FLASH_COMMAND, CMD_ERASE_ALL);
      repeat (3) @(posedge i_ref_clk);
      #1;
      i_reset = 1'b1;
      @(posedge i_ref_clk);
      #1;
      check("stall in reset", {31'h0, stall}, 32'h0);
      check("rdata in reset", {24'h0, rdata}, 32'h0);
      i_reset = 1'b0;
      @(posedge i_ref_clk);
      #1;
      check("stall after reset", {31'h0, stall}, 32'h0);
      expect_reg(ADDR_PAGE_SELECT, RST_PAGE_SELECT);
      expect_reg(ADDR_FLASH_COMMAND, RST_FLASH_COMMAND);
      expect_reg(ADDR_TIMING_WORD_LOW, 8'h52);
      $display("test reset in mid-run done");
   endtask

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Whole run needs about 3600 cycles; allow over five times that
   initial
   begin
      #400000;
      n_fail++;
      tally_and_finish();
   end

   initial
   begin
      i_reset = 1'b1;
      repeat (6) @(posedge i_ref_clk);
      #1;
      i_reset = 1'b0;
      t_reset_values();
      t_program_verify();
      t_erase();
      t_busy_drop();
      t_modify_byte();
      t_reset_mid();
      tally_and_finish();
   end
endmodule
